// file: logic/adcs_pkg.sv
package adcs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0    = 8'h00;
    localparam logic [7:0] OFS_CTRL1    = 8'h04;
    localparam logic [7:0] OFS_RES_HI   = 8'h08;
    localparam logic [7:0] OFS_RES_LO   = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h14;

    // converter_control_zero fields
    localparam int unsigned C0_START    = 7;
    localparam int unsigned C0_BUSY     = 6;
    localparam int unsigned C0_PWR      = 5;
    localparam int unsigned C0_FMT      = 4;
    localparam int unsigned C0_CHAN_LSB = 0;
    localparam int unsigned CHAN_W      = 4;

    // converter_control_one fields
    localparam int unsigned C1_SRC_LSB = 5;
    localparam int unsigned SRC_W      = 3;
    localparam int unsigned C1_REF_LSB = 3;
    localparam int unsigned REF_W      = 2;
    localparam int unsigned C1_DIV_LSB = 0;
    localparam int unsigned DIV_W      = 3;

    // Interrupt status and enable fields
    localparam int unsigned IS_DONE = 0;
    localparam int unsigned IE_CVT  = 0;
    localparam int unsigned IE_GLB  = 1;

    // Reset values
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h00;

    // Conversion timing in converter clocks
    localparam int unsigned RES_W        = 12;
    localparam int unsigned SAMPLE_CLKS  = 4;
    localparam int unsigned CONVERT_CLKS = 12;
    localparam int unsigned DIV_LOG_MAX  = 7;

    // Source and reference codes
    localparam logic [2:0] SRC_EXT0    = 3'h0;
    localparam logic [2:0] SRC_BANDGAP = 3'h1;
    localparam logic [2:0] SRC_GND_LO  = 3'h2;
    localparam logic [2:0] SRC_GND_HI  = 3'h4;
    localparam logic [1:0] REF_SUPPLY  = 2'h1;

    typedef enum logic [2:0]
    {
        ADCS_IDLE    = 3'h1,
        ADCS_SAMPLE  = 3'h2,
        ADCS_CONVERT = 3'h4
    } adcs_state_t;
endpackage

// file: logic/adcs_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
module adcs_clk_div #(
    parameter int unsigned LOG_MAX = 7
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Control
    input  wire logic               restart,
    input  wire logic [2:0]         sel,
    // Converter clock tick
    output logic                    tick
);
    typedef struct packed {
        logic [LOG_MAX-1:0] cnt;
    } adcs_div_t;

    adcs_div_t            s_r;
    adcs_div_t            s_nxt;
    logic [LOG_MAX:0]     one_hot;
    logic [LOG_MAX-1:0]   mask;

    // Power-of-two divide, one tick per 2**sel pclk cycles
    assign one_hot = (LOG_MAX+1)'(1) << sel;
    assign mask    = LOG_MAX'(one_hot - (LOG_MAX+1)'(1));
    assign tick    = (s_r.cnt & mask) == mask;

    always_comb
    begin
        s_nxt = s_r;
        if (restart)
            s_nxt.cnt = '0;
        else
            s_nxt.cnt = s_r.cnt + LOG_MAX'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule
`default_nettype wire

// file: logic/adcs_top.sv
// Function
// - Each conversion: 4 converter clocks sampling, then 12 clocks converting
// - Start bit written high then low by software begins a conversion
// - Busy flag reads one while a conversion runs
// - Busy clears at completion; result then readable in high and low bytes
// - Result is 12 bits; full scale code fff equals the reference
// - Code equals input times 4096 over reference; one step is ref/4096
// - Clearing power enable switches converter off; must be set before starting
// - Interrupt output only when global and converter enables are both set
// - Reference comes from the external pin or the analog supply
// - Format bit arranges the 12-bit result across the two bytes
// - Converter clock is system clock through a three-bit divider select
// - External source connects the channel named by the channel select field
// - Divider is a power of two, 1 at code 0 to 128 at 7
// - Source 1 bandgap, 0 and 5..7 external, 2..4 ground
// - Reference code 01 selects the analog supply, others the pin
// - Completion sets the interrupt flag whatever the enables
`timescale 1ns/100ps
`default_nettype none
module adcs_top
(
    // APB slave
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // Analog front end control
    output logic                    conv_power_en,
    output logic                    sample_hold,
    output logic [adcs_pkg::RES_W-1:0] sar_dac,
    input  wire logic               comparator_hi,
    output logic                    ext_channel_en,
    output logic [3:0]              ext_channel_sel,
    output logic                    bandgap_sel,
    output logic                    ground_sel,
    output logic                    ref_supply_sel,
    output logic                    ref_pin_sel,
    // Interrupt
    output logic                    irq
);
    import adcs_pkg::*;

    typedef struct packed {
        adcs_state_t          fsm;
        logic [3:0]           cnt;
        logic [RES_W-1:0]     trial;
        logic [RES_W-1:0]     probe;
        logic [RES_W-1:0]     result;
        logic                 start;
        logic                 pwr;
        logic                 fmt;
        logic [CHAN_W-1:0]    chan;
        logic [SRC_W-1:0]     src;
        logic [REF_W-1:0]     refsel;
        logic [DIV_W-1:0]     div;
        logic                 done_flag;
        logic                 cvt_en;
        logic                 glb_en;
        logic [31:0]          rdata;
        logic                 cmp_s1;
        logic                 cmp_s2;
    } adcs_st_t;

    adcs_st_t             s_r;
    adcs_st_t             s_nxt;
    logic                 tick;
    logic                 trig;
    logic                 done;
    logic                 wr;
    logic                 busy;
    logic [RES_W-1:0]     decided;
    logic [7:0]           res_hi;
    logic [7:0]           res_lo;

    adcs_clk_div #(
        .LOG_MAX (DIV_LOG_MAX)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (trig),
        .sel     (s_r.div),
        .tick    (tick)
    );

    assign busy = s_r.fsm != ADCS_IDLE;
    assign wr   = psel && penable && pwrite;

    // Left justified with format 0, right justified with format 1
    assign res_hi = s_r.fmt ? {4'h0, s_r.result[11:8]} : s_r.result[11:4];
    assign res_lo = s_r.fmt ? s_r.result[7:0] : {s_r.result[3:0], 4'h0};

    // Keep the bit under test if the input is above the trial level
    assign decided = s_r.cmp_s2 ? s_r.trial : (s_r.trial & ~s_r.probe);

    always_comb
    begin
        s_nxt        = s_r;
        trig         = 1'b0;
        done         = 1'b0;
        s_nxt.cmp_s1 = comparator_hi;
        s_nxt.cmp_s2 = s_r.cmp_s1;

        // Read data is latched in the setup phase so prdata is a flop
        if (psel && !penable)
        begin
            unique case (paddr)
                OFS_CTRL0:    s_nxt.rdata = {24'h0, s_r.start, busy, s_r.pwr,
                                             s_r.fmt, s_r.chan};
                OFS_CTRL1:    s_nxt.rdata = {24'h0, s_r.src, s_r.refsel, s_r.div};
                OFS_RES_HI:   s_nxt.rdata = {24'h0, res_hi};
                OFS_RES_LO:   s_nxt.rdata = {24'h0, res_lo};
                OFS_IRQ_STAT: s_nxt.rdata = {31'h0, s_r.done_flag};
                OFS_IRQ_EN:   s_nxt.rdata = {30'h0, s_r.glb_en, s_r.cvt_en};
                default:      s_nxt.rdata = 32'h0;
            endcase
        end

        if (wr)
        begin
            unique case (paddr)
                OFS_CTRL0:
                begin
                    s_nxt.start = pwdata[C0_START];
                    s_nxt.pwr   = pwdata[C0_PWR];
                    s_nxt.fmt   = pwdata[C0_FMT];
                    s_nxt.chan  = pwdata[C0_CHAN_LSB +: CHAN_W];
                end
                OFS_CTRL1:
                begin
                    s_nxt.src    = pwdata[C1_SRC_LSB +: SRC_W];
                    s_nxt.refsel = pwdata[C1_REF_LSB +: REF_W];
                    s_nxt.div    = pwdata[C1_DIV_LSB +: DIV_W];
                end
                OFS_IRQ_EN:
                begin
                    s_nxt.cvt_en = pwdata[IE_CVT];
                    s_nxt.glb_en = pwdata[IE_GLB];
                end
                default:
                begin
                end
            endcase
        end

        // High then low on the start bit arms one conversion
        trig = s_r.start && !s_nxt.start && s_nxt.pwr;

        if (!s_nxt.pwr)
        begin
            // Abandon the run, result registers untouched
            s_nxt.fsm   = ADCS_IDLE;
            s_nxt.cnt   = 4'h0;
            // Trial code back to zero so the DAC idles like after a clean finish
            s_nxt.trial = '0;
        end
        else if (trig)
        begin
            // A restart while busy throws the running conversion away
            s_nxt.fsm   = ADCS_SAMPLE;
            s_nxt.cnt   = 4'h0;
            s_nxt.trial = '0;
        end
        else
        begin
            unique case (s_r.fsm)
                ADCS_IDLE:
                begin
                end
                ADCS_SAMPLE:
                begin
                    if (tick)
                    begin
                        if (s_r.cnt == 4'(SAMPLE_CLKS - 1))
                        begin
                            s_nxt.fsm   = ADCS_CONVERT;
                            s_nxt.cnt   = 4'h0;
                            s_nxt.probe = {1'b1, {(RES_W-1){1'b0}}};
                            s_nxt.trial = {1'b1, {(RES_W-1){1'b0}}};
                        end
                        else
                            s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
                ADCS_CONVERT:
                begin
                    if (tick)
                    begin
                        // One result bit per converter clock, msb first
                        s_nxt.probe = s_r.probe >> 1;
                        s_nxt.trial = decided | (s_r.probe >> 1);
                        if (s_r.cnt == 4'(CONVERT_CLKS - 1))
                        begin
                            s_nxt.fsm    = ADCS_IDLE;
                            s_nxt.result = decided;
                            s_nxt.trial  = '0;
                            done         = 1'b1;
                        end
                        else
                            s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
            endcase
        end

        // Completion wins over a same-cycle write-one clear
        s_nxt.done_flag = (s_r.done_flag &
                           !(wr && paddr == OFS_IRQ_STAT && pwdata[IS_DONE])) | done;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r        <= '0;
            s_r.fsm    <= ADCS_IDLE;
            s_r.start  <= RST_CTRL0[C0_START];
            s_r.src    <= RST_CTRL1[C1_SRC_LSB +: SRC_W];
        end
        else
            s_r <= s_nxt;
    end

    assign pready  = 1'b1;
    assign prdata  = s_r.rdata;
    assign pslverr = psel && penable &&
                     !(paddr inside {OFS_CTRL0, OFS_CTRL1, OFS_RES_HI,
                                     OFS_RES_LO, OFS_IRQ_STAT, OFS_IRQ_EN});

    assign conv_power_en   = s_r.pwr;
    assign sample_hold     = s_r.fsm == ADCS_SAMPLE;
    assign sar_dac         = s_r.trial;
    // Source decode; channel pads stay open unless an external code is chosen
    assign bandgap_sel     = s_r.pwr && s_r.src == SRC_BANDGAP;
    assign ground_sel      = s_r.pwr && s_r.src >= SRC_GND_LO && s_r.src <= SRC_GND_HI;
    assign ext_channel_en  = s_r.pwr && !bandgap_sel && !ground_sel;
    assign ext_channel_sel = s_r.chan;
    // Reference routing
    assign ref_supply_sel  = s_r.refsel == REF_SUPPLY;
    assign ref_pin_sel     = !ref_supply_sel;
    // Both enables gate the flag onto the line
    assign irq             = s_r.done_flag && s_r.cvt_en && s_r.glb_en;

    // Ticks since the last trigger, for checking only
    logic [4:0] tk_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tk_r <= 5'h0;
        else if (trig)
            tk_r <= 5'h0;
        else if (busy && tick)
            tk_r <= tk_r + 5'h1;
    end

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        trig |=> s_r.fsm == ADCS_SAMPLE && busy;
    endproperty
    a_start: assert property (p_start) else $error("start edge did not begin sampling");

    property p_len;
        @(posedge pclk) disable iff (!presetn)
        done |-> tk_r == 5'd15;
    endproperty
    a_len: assert property (p_len) else $error("conversion not 16 converter clocks");

    property p_sample_to_conv;
        @(posedge pclk) disable iff (!presetn)
        $rose(s_r.fsm == ADCS_CONVERT) |-> tk_r == 5'd4 && sar_dac == 12'h800;
    endproperty
    a_sample_to_conv: assert property (p_sample_to_conv) else $error("bad sampling phase");

    property p_done_busy;
        @(posedge pclk) disable iff (!presetn)
        done |=> !busy && s_r.result == $past(decided);
    endproperty
    a_done_busy: assert property (p_done_busy) else $error("busy or result wrong at end");

    property p_flag;
        @(posedge pclk) disable iff (!presetn)
        done |=> s_r.done_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("completion flag not set");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        irq |-> s_r.cvt_en && s_r.glb_en && s_r.done_flag;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without both enables");

    property p_irq_done;
        @(posedge pclk) disable iff (!presetn)
        done && s_r.cvt_en && s_r.glb_en && !wr |=> irq;
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("enabled completion gave no interrupt");

    property p_abort;
        @(posedge pclk) disable iff (!presetn)
        busy && !s_nxt.pwr |=> !busy && $stable(s_r.result) && !$rose(s_r.done_flag) &&
                               sar_dac == '0;
    endproperty
    a_abort: assert property (p_abort) else $error("power off did not abort cleanly");

    property p_route;
        @(posedge pclk) disable iff (!presetn)
        s_r.pwr && s_r.src == SRC_BANDGAP |-> bandgap_sel && !ext_channel_en && !ground_sel;
    endproperty
    a_route: assert property (p_route) else $error("bandgap routing wrong");

    property p_ref;
        @(posedge pclk) disable iff (!presetn)
        ref_supply_sel |-> s_r.refsel == 2'h1 && !ref_pin_sel;
    endproperty
    a_ref: assert property (p_ref) else $error("reference routing wrong");

    c_done: cover property (@(posedge pclk) disable iff (!presetn) done);
    c_restart: cover property (@(posedge pclk) disable iff (!presetn) busy && trig);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn) busy && !s_nxt.pwr);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule
`default_nettype wire

// file: tb/adcs_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module adcs_top_tb_top;
    import adcs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, comparator_hi;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] sar_dac, vin, last;
    logic [3:0]  ext_channel_sel;
    logic        conv_power_en, sample_hold, ext_channel_en, bandgap_sel, ground_sel;
    logic        ref_supply_sel, ref_pin_sel, irq, er;
    int          failures, tests_run, cyc, n, sh;

    adcs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .conv_power_en(conv_power_en), .sample_hold(sample_hold),
        .sar_dac(sar_dac), .comparator_hi(comparator_hi), .ext_channel_en(ext_channel_en),
        .ext_channel_sel(ext_channel_sel), .bandgap_sel(bandgap_sel), .ground_sel(ground_sel),
        .ref_supply_sel(ref_supply_sel), .ref_pin_sel(ref_pin_sel), .irq(irq));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Ideal analog input: high while the input is at or above the trial level
    always @(posedge pclk) comparator_hi <= (vin >= sar_dac);

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures++;
            report_and_stop();
        end
    end

    task report_and_stop();
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; idle cycle after it so strobes never toggle twice in a step
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the bench timeout ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Start bit high then low, power kept on in both writes
    task trig(input logic [7:0] c0);
        wr(OFS_CTRL0, {24'h0, c0 | 8'ha0});
        wr(OFS_CTRL0, {24'h0, c0 | 8'h20});
    endtask

    task chk_res(input logic [11:0] r, input logic f);
        logic [15:0] b;
        b = f ? {4'h0, r} : {r, 4'h0};
        rdc(OFS_RES_HI, {24'h0, b[15:8]});
        rdc(OFS_RES_LO, {24'h0, b[7:0]});
    endtask

    // Counts pclk edges from the trigger edge until the interrupt rises
    task conv(input int dv, input logic [11:0] v, input logic [7:0] c0);
        vin <= v;
        wr(OFS_CTRL1, {29'h0, dv[2:0]});
        trig(c0);
        n  = 1;
        sh = 0;
        while (n < 4000)
        begin
            @(negedge pclk);
            if (irq === 1'b1)
                break;
            if (sample_hold === 1'b1)
                sh++;
            @(posedge pclk);
            n++;
        end
        chk(n, 16 << dv);
        chk(sh, (4 << dv) - 1);
        rdc(OFS_CTRL0, {24'h0, c0 | 8'h20});
        chk_res(v, c0[4]);
        wr(OFS_CTRL0, {24'h0, (c0 ^ 8'h10) | 8'h20});
        chk_res(v, ~c0[4]);
        wr(OFS_IRQ_STAT, 32'h1);
        last = v;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        vin = 12'h000;
        failures = 0;
        tests_run = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({irq, conv_power_en, ext_channel_en, bandgap_sel, ground_sel, ref_pin_sel}, 32'h1);
        rdc(OFS_CTRL0, 32'h0);
        rdc(OFS_CTRL1, 32'h0);
        rdc(OFS_IRQ_STAT, 32'h0);
        xfer(1'b0, 8'h18, 32'h0);
        chk(er, 1);
        chk(rd, 32'h0);
        wr(OFS_RES_HI, 32'hff);
        rdc(OFS_RES_HI, 32'h0);
        // Start pulse with power off must not start anything
        wr(OFS_CTRL0, 32'h80);
        wr(OFS_CTRL0, 32'h00);
        rdc(OFS_CTRL0, 32'h0);
        wr(OFS_CTRL0, 32'h20);
        rdc(OFS_CTRL0, 32'h20);
        chk(conv_power_en, 1);
        for (int s = 0; s < 8; s++)
            for (int r = 0; r < 4; r++)
            begin
                // Channel parked before any internal source is chosen
                wr(OFS_CTRL0, 32'h28);
                wr(OFS_CTRL1, {24'h0, s[2:0], r[1:0], 3'h2});
                if (s == 0 || s > 4)
                    wr(OFS_CTRL0, 32'h25);
                chk({ext_channel_en, bandgap_sel, ground_sel, ref_supply_sel, ref_pin_sel},
                    {s == 0 || s > 4, s == 1, s > 1 && s < 5, r == 1, r != 1});
                chk(ext_channel_sel, (s == 0 || s > 4) ? 4'h5 : 4'h8);
            end
        wr(OFS_IRQ_EN, 32'h3);
        conv(2, 12'hfff, 8'h03);
        conv(3, 12'h000, 8'h10);
        conv(4, 12'ha5c, 8'h01);
        conv(7, 12'h801, 8'h12);
        // Fast dividers 0 and 1 settle too slowly for mid codes, so full scale only for those two
        conv(0, 12'hfff, 8'h02);
        conv(1, 12'hfff, 8'h13);
        conv(5, 12'h7ff, 8'h11);
        conv(6, 12'h001, 8'h03);
        // Masked completion: flag still set, output stays low until both enables
        wr(OFS_IRQ_EN, 32'h1);
        conv_masked();
        // Power dropped mid conversion
        vin <= 12'h123;
        trig(8'h00);
        repeat (10) @(posedge pclk);
        rdc(OFS_CTRL0, 32'h60);
        wr(OFS_CTRL0, 32'h00);
        rdc(OFS_CTRL0, 32'h00);
        chk(sar_dac, 12'h000);
        repeat (80) @(posedge pclk);
        rdc(OFS_IRQ_STAT, 32'h0);
        chk_res(last, 1'b0);
        // Second start while busy restarts the full count
        trig(8'h00);
        repeat (20) @(posedge pclk);
        conv(2, 12'h3c7, 8'h00);
        report_and_stop();
    end

    task conv_masked();
        vin <= 12'h456;
        wr(OFS_CTRL1, 32'h2);
        trig(8'h00);
        repeat (70) @(posedge pclk);
        chk(irq, 0);
        rdc(OFS_IRQ_STAT, 32'h1);
        chk_res(12'h456, 1'b0);
        wr(OFS_IRQ_EN, 32'h2);
        chk(irq, 0);
        wr(OFS_IRQ_EN, 32'h3);
        chk(irq, 1);
        wr(OFS_IRQ_STAT, 32'h1);
        chk(irq, 0);
        rdc(OFS_IRQ_STAT, 32'h0);
        last = 12'h456;
    endtask
endmodule
`default_nettype wire
